// File: asc_regs.vh
/*
 * Register map, field positions, reset values and timing codes of the
 * converter sequence control block.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef ASC_REGS_VH
`define ASC_REGS_VH

// ----------------------------------------------------------------
// Register byte addresses (word aligned, index times four).
// ----------------------------------------------------------------
`define ASC_IDX_CTRL_A 8'h1c
`define ASC_IDX_LSB_STAT 8'h1e
`define ASC_IDX_MSB 8'h1f
`define ASC_IDX_CTRL_B 8'h1d
`define ASC_ADDR_W 10
`define ASC_ADDR_CTRL_A 10'h070
`define ASC_ADDR_CTRL_B 10'h074
`define ASC_ADDR_LSB_STAT 10'h078
`define ASC_ADDR_MSB 10'h07c

// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define ASC_CTRL_A_RST 8'h10
`define ASC_CTRL_B_RST 8'h10
`define ASC_MSB_RST 8'h00

// ----------------------------------------------------------------
// Field positions of control register A.
// ----------------------------------------------------------------
`define ASC_A_START 7
`define ASC_A_MODE_HI 6
`define ASC_A_MODE_LO 5
`define ASC_A_AIN_DIS 4
`define ASC_A_CH_HI 3
`define ASC_A_CH_LO 0

// ----------------------------------------------------------------
// Field positions of control register B and status register.
// ----------------------------------------------------------------
`define ASC_B_LADDER 5
`define ASC_B_TIME_HI 3
`define ASC_B_TIME_LO 1
`define ASC_B_KEEP_LO 5
`define ASC_S_DONE 5
`define ASC_S_BUSY 4

// ----------------------------------------------------------------
// Operating modes and conversion time codes.
// ----------------------------------------------------------------
`define ASC_MODE_OFF 2'b00
`define ASC_MODE_SINGLE 2'b01
`define ASC_MODE_REPEAT 2'b11
`define ASC_CH_LAST 4'h7
`define ASC_T39 3'b000
`define ASC_T78 3'b010
`define ASC_T156 3'b011
`define ASC_T312 3'b100
`define ASC_T624 3'b101
`define ASC_T1248 3'b110
`define ASC_CYC39 11'd39
`define ASC_CYC_W 11

`endif

// File: asc_sync.v
/*
 * Two-stage synchroniser for a single level.
 * Assumes the input comes from outside the ref_clk_i domain.
 */
module asc_sync (
	// Clock and reset.
	input wire ref_clk_i,
	input wire rst_n_i,
	// Level in and out.
	input wire d_i,
	output reg q_o
);
	reg meta_reg;

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule // asc_sync

// File: asc_conv_timer.v
/*
 * Conversion length counter: counts ref_clk_i cycles of one conversion.
 * Assumes load and abort come from the same clock domain.
 */
`include "asc_regs.vh"

module asc_conv_timer (
	// Clock and reset.
	input wire ref_clk_i,
	input wire rst_n_i,
	// Control.
	input wire load_i,
	input wire abort_i,
	input wire [2:0] time_code_i,
	// Status.
	output reg running_o,
	output wire end_o
);
	reg [`ASC_CYC_W-1:0] count_reg;

	// Cycle count for each time code; reserved codes fall back to the shortest.
	function [`ASC_CYC_W-1:0] asc_cycles;
		input [2:0] code;
		begin
			case (code)
				`ASC_T78: asc_cycles = `ASC_CYC39 << 1;
				`ASC_T156: asc_cycles = `ASC_CYC39 << 2;
				`ASC_T312: asc_cycles = `ASC_CYC39 << 3;
				`ASC_T624: asc_cycles = `ASC_CYC39 << 4;
				`ASC_T1248: asc_cycles = `ASC_CYC39 << 5;
				default: asc_cycles = `ASC_CYC39;
			endcase
		end
	endfunction

	assign end_o = running_o && (count_reg == {{(`ASC_CYC_W-1){1'b0}}, 1'b1}) && !abort_i;

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_reg <= {`ASC_CYC_W{1'b0}};
			running_o <= 1'b0;
		end else if (abort_i) begin
			running_o <= 1'b0;
			count_reg <= {`ASC_CYC_W{1'b0}};
		end else if (load_i) begin
			running_o <= 1'b1;
			count_reg <= asc_cycles(time_code_i);
		end else if (running_o) begin
			count_reg <= count_reg - {{(`ASC_CYC_W-1){1'b0}}, 1'b1};
			if (end_o)
				running_o <= 1'b0;
		end
	end
endmodule // asc_conv_timer

// File: asc_seq_ctrl.v
/*
 * Sequence control and status of a 10-bit successive-approximation
 * converter, with an Avalon-MM slave for its four registers.
 * Assumes the analog core delivers a 10-bit code at the end of each
 * conversion, and a standby request level from the power controller.
 */
// The Avalon-MM slave port was decided locally.
// Function
// - Start bit with single mode begins one conversion, then clears itself.
// - Mode field: 00 disabled, 01 single start, 11 repeat, 10 reserved.
// - Analog input control bit: 0 enables inputs, 1 disables them.
// - Channel field codes 0000-0111 select inputs 0-7; above reserved.
// - Standby entry resets both control registers and blocks their writes.
// - Ladder bit 0 connects network during conversion only; 1 always.
// - Time field gives 39, 78, 156, 312, 624 or 1248 cycles.
// - Register B top two bits read undefined.
// - Result bits 9-2 in upper register; bits 1-0 in status bits 7-6.
// - Completion stores result, sets done flag, raises interrupt together.
// - Reading the upper result register clears the done flag.
// - Busy flag set at start, cleared at end and on standby entry.
// - Status low four bits read unstable, meaningless values.
// - Repeat mode starts a new conversion after each completion.
// - Writing mode 00 aborts conversion and discards partial result.
// - New start clears done flag but keeps old result until completion.
`include "asc_regs.vh"

module asc_seq_ctrl (
	// Clock and reset.
	input wire ref_clk_i,
	input wire rst_n_i,
	// Avalon-MM slave.
	input wire [`ASC_ADDR_W-1:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	// Power and analog core.
	input wire standby_i,
	input wire [9:0] conv_code_i,
	input wire [3:0] noise_bits_i,
	output wire sample_o,
	output wire [3:0] channel_select_o,
	output wire analog_input_disable_o,
	output wire ladder_connect_o,
	// Events.
	output wire conv_done_irq_o
);
	reg [7:0] ctrl_a_reg;
	reg [7:0] ctrl_b_reg;
	reg [7:0] msb_reg;
	reg [1:0] lsb_reg;
	reg done_reg;
	reg ack_reg;
	reg start_reg;
	reg standby_q_reg;
	reg [1:0] rd_undef_reg;
	wire standby_s;
	wire running;
	wire conv_end;
	wire acc;
	wire take;
	wire wr_ctrl_a;
	wire wr_ctrl_b;
	wire rd_msb;
	wire [1:0] mode;
	wire abort;
	wire restart;
	wire standby_rise;

	// ------------------------------------------------------------
	// Standby request synchroniser.
	// ------------------------------------------------------------
	asc_sync u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(standby_i),
		.q_o(standby_s)
	);

	// ------------------------------------------------------------
	// Bus decode: one wait state, answer on the second edge.
	// ------------------------------------------------------------
	assign acc = (avs_read_i || avs_write_i) && !ack_reg;
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
	// Side effects land only at the edge where waitrequest is seen low.
	assign take = (avs_read_i || avs_write_i) && ack_reg;
	assign wr_ctrl_a = take && avs_write_i && avs_byteenable_i[0] &&
		(avs_address_i == `ASC_ADDR_CTRL_A) && !standby_s;
	assign wr_ctrl_b = take && avs_write_i && avs_byteenable_i[0] &&
		(avs_address_i == `ASC_ADDR_CTRL_B) && !standby_s;
	assign rd_msb = take && avs_read_i && (avs_address_i == `ASC_ADDR_MSB);

	assign mode = ctrl_a_reg[`ASC_A_MODE_HI:`ASC_A_MODE_LO];
	assign abort = running && (mode == `ASC_MODE_OFF);
	assign restart = conv_end && (mode == `ASC_MODE_REPEAT);
	assign standby_rise = standby_s && !standby_q_reg;

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= acc;
	end

	// ------------------------------------------------------------
	// Control registers.
	// ------------------------------------------------------------
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_a_reg <= `ASC_CTRL_A_RST;
			ctrl_b_reg <= `ASC_CTRL_B_RST;
			standby_q_reg <= 1'b0;
		end else begin
			standby_q_reg <= standby_s;
			if (standby_s) begin
				ctrl_a_reg <= `ASC_CTRL_A_RST;
				ctrl_b_reg <= `ASC_CTRL_B_RST;
			end else begin
				if (wr_ctrl_a)
					ctrl_a_reg <= avs_writedata_i[7:0];
				else if (start_reg)
					ctrl_a_reg[`ASC_A_START] <= 1'b0;
				if (wr_ctrl_b)
					ctrl_b_reg <= avs_writedata_i[7:0];
			end
		end
	end

	// Start request seen one cycle after the bit is written, then cleared.
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			start_reg <= 1'b0;
		else
			start_reg <= ctrl_a_reg[`ASC_A_START] && !start_reg && !standby_s &&
				((mode == `ASC_MODE_SINGLE) || (mode == `ASC_MODE_REPEAT));
	end

	// ------------------------------------------------------------
	// Conversion timer.
	// ------------------------------------------------------------
	asc_conv_timer u_timer (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.load_i(start_reg || restart),
		.abort_i(abort || standby_s),
		.time_code_i(ctrl_b_reg[`ASC_B_TIME_HI:`ASC_B_TIME_LO]),
		.running_o(running),
		.end_o(conv_end)
	);

	// ------------------------------------------------------------
	// Result and done flag.
	// ------------------------------------------------------------
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			msb_reg <= `ASC_MSB_RST;
			lsb_reg <= 2'b00;
			done_reg <= 1'b0;
		end else if (standby_rise) begin
			msb_reg <= `ASC_MSB_RST;
			lsb_reg <= 2'b00;
			done_reg <= 1'b0;
		end else if (conv_end) begin
			msb_reg <= conv_code_i[9:2];
			lsb_reg <= conv_code_i[1:0];
			done_reg <= 1'b1;
		end else if (rd_msb || start_reg) begin
			done_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Analog side outputs.
	// ------------------------------------------------------------
	assign sample_o = running;
	assign channel_select_o = ctrl_a_reg[`ASC_A_CH_HI:`ASC_A_CH_LO];
	assign analog_input_disable_o = ctrl_a_reg[`ASC_A_AIN_DIS];
	assign ladder_connect_o = ctrl_b_reg[`ASC_B_LADDER] || running;
	assign conv_done_irq_o = conv_end;

	// ------------------------------------------------------------
	// Read data.
	// ------------------------------------------------------------
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rd_undef_reg <= 2'b00;
		else
			rd_undef_reg <= noise_bits_i[1:0];
	end

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (acc && avs_read_i) begin
			case (avs_address_i)
				`ASC_ADDR_CTRL_A: avs_readdata_o <= {24'h00_0000, ctrl_a_reg};
				`ASC_ADDR_CTRL_B:
					avs_readdata_o <= {24'h00_0000, rd_undef_reg, ctrl_b_reg[5:0]};
				`ASC_ADDR_LSB_STAT:
					avs_readdata_o <= {24'h00_0000, lsb_reg, done_reg, running,
						noise_bits_i};
				`ASC_ADDR_MSB: avs_readdata_o <= {24'h00_0000, msb_reg};
				default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule // asc_seq_ctrl

// File: asc_seq_ctrl_props.sv
/*
 * Checker of the converter sequence control block, bound to its ports.
 * Assumes the master holds each request until waitrequest is low.
 */
module asc_seq_ctrl_props (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Register bus.
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// Core side.
	input wire logic standby_i,
	input wire logic sample_o,
	input wire logic [3:0] channel_select_o,
	input wire logic analog_input_disable_o,
	input wire logic ladder_connect_o,
	input wire logic conv_done_irq_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ----------------------------------------
	// Accepted writes outside standby.
	// ----------------------------------------
	sequence s_wr(a);
		(!standby_i [*3]) ##0 (avs_write_i && !avs_waitrequest_o && avs_address_i == a
			&& avs_byteenable_i[0]);
	endsequence
	a_irq_one_pulse: assert property (conv_done_irq_o |=> !conv_done_irq_o)
		else $error("irq longer than one cycle");
	a_irq_not_early: assert property ($rose(sample_o) |=> !conv_done_irq_o [*8])
		else $error("irq too early");
	a_ladder_conv: assert property (sample_o |-> ladder_connect_o)
		else $error("ladder open in conversion");
	a_ladder_kept: assert property (s_wr(10'h074) ##0 avs_writedata_i[5] |=> ladder_connect_o)
		else $error("ladder not kept");
	a_ctrl_a_fields: assert property (s_wr(10'h070) |=> channel_select_o ==
		$past(avs_writedata_i[3:0]) && analog_input_disable_o == $past(avs_writedata_i[4]))
		else $error("channel or input control wrong");
	a_standby_clear: assert property (standby_i [*4] |-> channel_select_o == 4'h0
		&& analog_input_disable_o && !sample_o)
		else $error("standby did not clear");
	a_read_upper_zero: assert property (avs_read_i && !avs_waitrequest_o |->
		avs_readdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
		else $error("no wait state");
	a_wait_one: assert property (avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("wait state too long");
	cover property (conv_done_irq_o);
	cover property (standby_i [*4]);
	cover property (avs_read_i && !avs_waitrequest_o && avs_address_i == 10'h07c);
endmodule // asc_seq_ctrl_props

bind asc_seq_ctrl asc_seq_ctrl_props u_asc_seq_ctrl_props (.ref_clk_i, .rst_n_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
	.avs_readdata_o, .avs_waitrequest_o, .standby_i, .sample_o, .channel_select_o,
	.analog_input_disable_o, .ladder_connect_o, .conv_done_irq_o);

// File: tb.sv
/*
 * Self-checking testbench of the converter sequence control block.
 * Assumes the checker file binds itself to the design.
 */
`include "asc_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0, standby_i = 0;
	logic [9:0] avs_address_i = 0, conv_code_i = 0, old;
	logic [31:0] avs_writedata_i = 0, avs_readdata_o, exp_q[$], msk_q[$];
	logic [3:0] avs_byteenable_i = 4'hf, noise_bits_i = 0, channel_select_o, ch;
	logic avs_waitrequest_o, sample_o, analog_input_disable_o, ladder_connect_o;
	logic conv_done_irq_o;
	int fails = 0, checked = 0, seed = 32'h1dbbad26, n, n0, i;
	asc_seq_ctrl u_asc_seq_ctrl (.ref_clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
		.avs_waitrequest_o, .standby_i, .conv_code_i, .noise_bits_i, .sample_o,
		.channel_select_o, .analog_input_disable_o, .ladder_connect_o, .conv_done_irq_o);
	initial forever #12.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) noise_bits_i <= $random(seed);
	// ----------------------------------------
	// Shared tasks.
	// ----------------------------------------
	task automatic chk(input string s, input logic [31:0] x, y);
		checked++;
		if (x !== y) begin
			fails++;
			$display("[ERR] %s exp %h got %h", s, x, y);
		end
	endtask
	// A read passes its expected value in d and notes it for the monitor.
	task bus(input logic w, input logic [9:0] a, input logic [31:0] d, mk = 0);
		int k;
		@(posedge ref_clk_i);
		if (!w) begin
			exp_q.push_back(d);
			msk_q.push_back(mk);
		end
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		k = 0;
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 20);
		if (avs_waitrequest_o !== 1'b0) begin
			chk("waitrequest", 0, avs_waitrequest_o);
			complete_run;
		end
		avs_write_i <= 0;
		avs_read_i <= 0;
	endtask
	task wirq(output int c);
		c = 0;
		do begin
			@(posedge ref_clk_i);
			c++;
		end while (conv_done_irq_o !== 1'b1 && c < 3000);
		if (conv_done_irq_o !== 1'b1) begin
			chk("irq", 1, conv_done_irq_o);
			complete_run;
		end
	endtask
	task complete_run;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(posedge ref_clk_i) if (avs_read_i && avs_waitrequest_o === 1'b0)
		chk("readdata", exp_q.pop_front(), avs_readdata_o & msk_q.pop_front());
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		$display("[ERR] timeout exp 0 got 1");
		fails++;
		complete_run;
	end
	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial begin
		ch = $random(seed) & 7;
		repeat (12) @(posedge ref_clk_i);
		rst_n_i <= 1;
		bus(0, `ASC_ADDR_CTRL_A, 32'h10, 32'hff);
		bus(0, `ASC_ADDR_CTRL_B, 32'h10, 32'h3f);
		bus(0, `ASC_ADDR_LSB_STAT, 0, 32'h30);
		bus(0, `ASC_ADDR_MSB, 0, 32'hff);
		bus(0, 10'h3f0, 0, 32'hffffffff);
		for (i = 0; i < 6; i++) begin
			conv_code_i <= $random(seed);
			bus(1, `ASC_ADDR_CTRL_B, {26'h0, i[0], 1'b1, 3'(i ? i + 1 : 0), 1'b0});
			bus(1, `ASC_ADDR_CTRL_A, {24'h0, 4'ha, ch});
			wirq(n);
			if (i == 0) n0 = n;
			chk("length", (i ? 39 << i : 39) - 39, n - n0);
			bus(0, `ASC_ADDR_LSB_STAT, {conv_code_i[1:0], 6'h20}, 32'hf0);
			bus(0, `ASC_ADDR_MSB, conv_code_i[9:2], 32'hff);
			bus(0, `ASC_ADDR_LSB_STAT, 0, 32'h20);
			chk("channel", ch, channel_select_o);
			chk("input disable", 0, analog_input_disable_o);
			chk("ladder", i[0], ladder_connect_o);
		end
		bus(0, `ASC_ADDR_CTRL_A, {4'h2, ch}, 32'hff);
		bus(1, `ASC_ADDR_CTRL_B, 32'h10);
		old = conv_code_i;
		bus(1, `ASC_ADDR_CTRL_A, {4'ha, ch});
		wirq(n);
		conv_code_i <= old ^ 10'h3ff;
		bus(1, `ASC_ADDR_CTRL_A, {4'ha, ch});
		// Let the start reach the status flags before reading them back.
		repeat (2) @(posedge ref_clk_i);
		bus(0, `ASC_ADDR_LSB_STAT, 32'h10, 32'h30);
		bus(0, `ASC_ADDR_MSB, old[9:2], 32'hff);
		wirq(n);
		bus(0, `ASC_ADDR_MSB, conv_code_i[9:2], 32'hff);
		bus(1, `ASC_ADDR_CTRL_A, {4'he, ch});
		wirq(n);
		wirq(n);
		chk("repeat", 39, n);
		old = conv_code_i;
		conv_code_i <= old ^ 10'h155;
		repeat (10) @(posedge ref_clk_i);
		bus(1, `ASC_ADDR_CTRL_A, {4'h0, ch});
		n = 0;
		repeat (60) @(posedge ref_clk_i) n += conv_done_irq_o;
		chk("abort irq", 0, n);
		chk("abort sample", 0, sample_o);
		bus(0, `ASC_ADDR_MSB, old[9:2], 32'hff);
		standby_i <= 1;
		repeat (6) @(posedge ref_clk_i);
		bus(1, `ASC_ADDR_CTRL_A, 32'h2f);
		bus(0, `ASC_ADDR_CTRL_A, 32'h10, 32'hff);
		chk("standby disable", 1, analog_input_disable_o);
		standby_i <= 0;
		repeat (4) @(posedge ref_clk_i);
		complete_run;
	end
endmodule // tb
